// ==== hw/cib_pkg.sv ====
// cib_pkg: register map, command layout, flags and timing for the instruction behaviour core
// assumes a 40 MHz system clock and a 32-bit apb master using byte addresses
`default_nettype none
package cib_pkg;
	localparam int          ADDR_W       = 8;
	// apb byte offsets, one aligned word each
	localparam logic [7:0]  OFS_CMD      = 8'h00;
	localparam logic [7:0]  OFS_OPA      = 8'h04;
	localparam logic [7:0]  OFS_OPB      = 8'h08;
	localparam logic [7:0]  OFS_RES      = 8'h0C;
	localparam logic [7:0]  OFS_FLAGS    = 8'h10;
	localparam logic [7:0]  OFS_PC       = 8'h14;
	localparam logic [7:0]  OFS_PTR      = 8'h18;
	localparam logic [7:0]  OFS_SSP      = 8'h1C;
	localparam logic [7:0]  OFS_USP      = 8'h20;
	localparam logic [7:0]  OFS_CTRL     = 8'h24;
	localparam logic [7:0]  OFS_IDX      = 8'h28;
	// the flag byte is register 231 of the register file
	localparam logic [7:0]  FLAG_REG_NUM = 8'hE7;
	// control register fields
	localparam int          CTRL_IE      = 0;
	localparam int          CTRL_WAIT    = 1;
	localparam int          CTRL_HALT    = 2;
	localparam int          CTRL_DMA     = 3;
	// reset values
	localparam logic [7:0]  RST_FLAGS    = 8'h00;
	localparam logic [15:0] RST_PC       = 16'h0000;
	localparam logic [15:0] RST_SP       = 16'h00FF;
	localparam logic [7:0]  RST_PTR      = 8'h00;
	// pointer and stack steps
	localparam logic [15:0] STEP_BYTE    = 16'h0001;
	localparam logic [15:0] STEP_WORD    = 16'h0002;
	// dma service slot while waiting, least time rounded up to cycles
	localparam int          CLK_MHZ      = 40;
	localparam int          DMA_SVC_NS   = 200;
	localparam int          DMA_SVC_CYC  = (DMA_SVC_NS * CLK_MHZ + 999) / 1000;
	localparam int          CNT_W        = 4;

	typedef enum logic [5:0] {
		OP_NOP, OP_WAIT_INT, OP_HALT, OP_CJF_INC, OP_CJT_INC, OP_BTB_F, OP_BTB_T,
		OP_DEC_BNZ, OP_PDEC_BNZ, OP_REL_BR, OP_WP_LONG, OP_WP_LOW, OP_WP_HIGH,
		OP_PUSH_S, OP_EA_PUSH_S, OP_PULL_S, OP_PUSH_U, OP_EA_PUSH_U, OP_PULL_U,
		OP_DIVIDE, OP_DIV_STEP, OP_ASR, OP_CROT_R, OP_CROT_L, OP_ASL, OP_IRQ_EXIT,
		OP_C_SET, OP_C_CLR, OP_C_INV, OP_PROD8, OP_INVERT, OP_PSPACE, OP_DSPACE
	} cib_op_e;

	typedef enum logic [3:0] {
		CC_F, CC_T, CC_C, CC_NC, CC_Z, CC_NZ, CC_PL, CC_MI,
		CC_OV, CC_NOV, CC_GE, CC_LT, CC_GT, CC_LE, CC_UGT, CC_ULE
	} cib_cond_e;

	typedef enum {ST_RUN, ST_WAIT, ST_DMA, ST_HALT} cib_state_e;

	// command word: disp [23:16], sel [11:8], wide [7], op [5:0]
	typedef struct packed {
		logic [7:0] disp;
		logic [3:0] rsvA;
		logic [3:0] sel;
		logic       wide;
		logic       rsvB;
		cib_op_e    op;
	} cib_cmd_s;

	// flag byte: c z s v d h user pd, msb first
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
		logic user;
		logic pd;
	} cib_flags_s;
endpackage
`default_nettype wire

// ==== hw/cib_core.sv ====
// cib_core: executes one decoded instruction per command write and keeps flags, pointers and stacks
// assumes an apb master on the same clock; irqReq and dmaReq are asynchronous pins
//
// What this block does
// RULE1: wait op idles until enabled interrupt
// RULE2: dma request while waiting serviced, then waits
// RULE3: halt op stops until reset only
// RULE4: compare, branch if false, else post-increment
// RULE5: compare, branch if true, else post-increment
// RULE6: bit test branches on clear or set
// RULE7: byte decrement, branch if nonzero
// RULE8: word pair decrement, branch if nonzero
// RULE9: relative branch only when condition true
// RULE10: long pointer maps sixteen working registers
// RULE11: low pointer places lower eight registers
// RULE12: high pointer places upper eight registers
// RULE13: system stack byte, word, address pushes
// RULE14: user stack pushes use own pointer
// RULE15: system stack pulls keep flags
// RULE16: user stack pulls keep flags
// RULE17: divide sets carry and decimal; stepped divide
// RULE18: right shift clears decimal, updates others
// RULE19: right rotate through carry flag effects
// RULE20: left rotate through carry flag effects
// RULE21: left shift updates carry, zero, sign
// RULE22: interrupt exit restores flags; carry ops
// RULE23: product clears decimal; invert clears overflow
// RULE24: flags live in register 231
// RULE25: bit 0 selects space, mirrored on pin
// RULE26: conditions use carry, zero, sign, overflow
//
// Implementation choices: register access over APB and the address map.
`default_nettype none
module cib_core
(
	input  wire logic                        clock,
	input  wire logic                        sys_rst,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [cib_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        irqReq,
	input  wire logic                        dmaReq,
	output logic                             pdSelect,
	output logic                             coreWaiting,
	output logic                             coreHalted,
	output logic                             dmaBusy
);
	import cib_pkg::*;

	logic [1:0]       irqSync_q;
	logic [1:0]       dmaSync_q;
	logic [15:0]      opA_q;
	logic [15:0]      opB_q;
	logic [15:0]      res_q;
	logic [15:0]      res_d;
	cib_flags_s       flags_q;
	cib_flags_s       flags_d;
	logic [15:0]      pc_q;
	logic [15:0]      pc_d;
	logic [15:0]      ssp_q;
	logic [15:0]      ssp_d;
	logic [15:0]      usp_q;
	logic [15:0]      usp_d;
	logic [15:0]      idx_q;
	logic [15:0]      idx_d;
	logic [7:0]       rp0_q;
	logic [7:0]       rp0_d;
	logic [7:0]       rp1_q;
	logic [7:0]       rp1_d;
	logic             ie_q;
	cib_state_e       state_q;
	cib_state_e       state_d;
	logic [CNT_W-1:0] dmaCnt_q;
	logic             waiting_q;
	logic             halted_q;
	logic             dmaBusy_q;
	logic [31:0]      rdData_q;
	logic             ready_q;
	logic             err_q;
	logic             taken;
	logic             goWait;
	logic             goHalt;

	// pins cross in two stages; the first stage feeds nothing else
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irqSync_q <= 2'h0;
			dmaSync_q <= 2'h0;
		end
		else
		begin
			irqSync_q <= {irqSync_q[0], irqReq};
			dmaSync_q <= {dmaSync_q[0], dmaReq};
		end
	end
	wire irqSeen = irqSync_q[1];
	wire dmaSeen = dmaSync_q[1];

	// apb decode; one wait state so read data comes from a flop
	wire apbAccess = psel & penable;
	wire apbFirst  = apbAccess & ~ready_q;
	wire wrDone    = apbAccess & ready_q & pwrite;
	wire hitCmd    = paddr == OFS_CMD;
	wire hitOpa    = paddr == OFS_OPA;
	wire hitOpb    = paddr == OFS_OPB;
	wire hitRes    = paddr == OFS_RES;
	wire hitFlags  = paddr == OFS_FLAGS;
	wire hitPc     = paddr == OFS_PC;
	wire hitPtr    = paddr == OFS_PTR;
	wire hitSsp    = paddr == OFS_SSP;
	wire hitUsp    = paddr == OFS_USP;
	wire hitCtrl   = paddr == OFS_CTRL;
	wire hitIdx    = paddr == OFS_IDX;
	wire hitAny    = hitCmd | hitOpa | hitOpb | hitRes | hitFlags | hitPc | hitPtr | hitSsp | hitUsp | hitCtrl | hitIdx;
	// a command offered while not running is refused with an error, never queued
	wire refuse    = ~hitAny | (hitCmd & pwrite & (state_q != ST_RUN)); // [RULE1] [RULE3]
	wire exeGo     = wrDone & hitCmd & ~err_q;
	wire [31:0] ctrlWord = {28'h0000000, dmaBusy_q, halted_q, waiting_q, ie_q};
	wire [31:0] rdMux =
		hitOpa   ? {16'h0000, opA_q} :
		hitOpb   ? {16'h0000, opB_q} :
		hitRes   ? {16'h0000, res_q} :
		hitFlags ? {16'h0000, FLAG_REG_NUM, flags_q} : // [RULE24]
		hitPc    ? {16'h0000, pc_q} :
		hitPtr   ? {16'h0000, rp1_q, rp0_q} :
		hitSsp   ? {16'h0000, ssp_q} :
		hitUsp   ? {16'h0000, usp_q} :
		hitCtrl  ? ctrlWord :
		hitIdx   ? {16'h0000, idx_q} : 32'h00000000;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ready_q  <= 1'b0;
			err_q    <= 1'b0;
			rdData_q <= 32'h00000000;
		end
		else
		begin
			ready_q <= apbFirst;
			if (apbFirst)
			begin
				err_q    <= refuse;
				rdData_q <= pwrite ? 32'h00000000 : rdMux;
			end
		end
	end

	// operand latches and interrupt enable, written by software only
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			opA_q <= 16'h0000;
			opB_q <= 16'h0000;
			ie_q  <= 1'b0;
		end
		else
		begin
			if (wrDone & hitOpa)
				opA_q <= pwdata[15:0];
			if (wrDone & hitOpb)
				opB_q <= pwdata[15:0];
			if (wrDone & hitCtrl)
				ie_q <= pwdata[CTRL_IE];
		end
	end

	// command fields and shared arithmetic
	cib_cmd_s cmdIn;
	assign cmdIn = cib_cmd_s'(pwdata[23:0]);
	wire        wd       = cmdIn.wide;
	wire        aSign    = wd ? opA_q[15] : opA_q[7];
	wire        opEqual  = wd ? (opA_q == opB_q) : (opA_q[7:0] == opB_q[7:0]);
	wire        bitSel   = wd ? opA_q[cmdIn.sel] : opA_q[{1'b0, cmdIn.sel[2:0]}];
	wire [15:0] stepSz   = wd ? STEP_WORD : STEP_BYTE;
	wire [15:0] brTarget = pc_q + {{8{cmdIn.disp[7]}}, cmdIn.disp};
	wire [15:0] prod     = opA_q[7:0] * opB_q[7:0];
	wire        divZero  = opB_q[7:0] == 8'h00;
	// a zero divisor gives all ones rather than an unknown quotient
	wire [15:0] quo      = divZero ? 16'hFFFF : opA_q / {8'h00, opB_q[7:0]};
	wire [15:0] rem      = divZero ? opA_q : opA_q % {8'h00, opB_q[7:0]};
	wire [16:0] stepRem  = {opA_q, flags_q.c};
	wire        stepFit  = stepRem >= {1'b0, opB_q};
	wire [16:0] stepSub  = stepRem - {1'b0, opB_q};

	function automatic logic isZero(input logic [15:0] v, input logic w);
		isZero = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
	endfunction

	function automatic logic signOf(input logic [15:0] v, input logic w);
		signOf = w ? v[15] : v[7];
	endfunction

	// conditions look only at c, z, s and v
	function automatic logic condMet(input logic [3:0] cc, input cib_flags_s f);
		logic lt;
		lt = f.s ^ f.v;
		case (cib_cond_e'(cc))
			CC_F:    condMet = 1'b0;
			CC_T:    condMet = 1'b1;
			CC_C:    condMet = f.c;
			CC_NC:   condMet = ~f.c;
			CC_Z:    condMet = f.z;
			CC_NZ:   condMet = ~f.z;
			CC_PL:   condMet = ~f.s;
			CC_MI:   condMet = f.s;
			CC_OV:   condMet = f.v;
			CC_NOV:  condMet = ~f.v;
			CC_GE:   condMet = ~lt;
			CC_LT:   condMet = lt;
			CC_GT:   condMet = ~(f.z | lt);
			CC_LE:   condMet = f.z | lt;
			CC_UGT:  condMet = ~f.c & ~f.z;
			CC_ULE:  condMet = f.c | f.z;
			default: condMet = 1'b0;
		endcase
	endfunction

	// execution: undefined flags are simply left as they were
	always_comb
	begin
		res_d   = res_q;
		flags_d = flags_q;
		ssp_d   = ssp_q;
		usp_d   = usp_q;
		idx_d   = idx_q;
		rp0_d   = rp0_q;
		rp1_d   = rp1_q;
		pc_d    = pc_q + STEP_BYTE;
		taken   = 1'b0;
		goWait  = 1'b0;
		goHalt  = 1'b0;
		case (cmdIn.op)
			OP_WAIT_INT: goWait = 1'b1; // [RULE1]
			OP_HALT:     goHalt = 1'b1; // [RULE3]
			OP_CJF_INC:
			begin
				taken = ~opEqual; // [RULE4]
				if (opEqual)
					idx_d = idx_q + stepSz;
			end
			OP_CJT_INC:
			begin
				taken = opEqual; // [RULE5]
				if (!opEqual)
					idx_d = idx_q + stepSz;
			end
			OP_BTB_F: taken = ~bitSel; // [RULE6]
			OP_BTB_T: taken = bitSel; // [RULE6]
			OP_DEC_BNZ:
			begin
				res_d = {8'h00, opA_q[7:0] - 8'h01}; // [RULE7]
				taken = opA_q[7:0] != 8'h01;
			end
			OP_PDEC_BNZ:
			begin
				res_d = opA_q - STEP_BYTE; // [RULE8]
				taken = opA_q != STEP_BYTE;
			end
			OP_REL_BR:  taken = condMet(cmdIn.sel, flags_q); // [RULE9] [RULE26]
			OP_WP_LONG:
			begin
				rp0_d = {opB_q[7:4], 4'h0}; // [RULE10]
				rp1_d = {opB_q[7:4], 4'h8};
			end
			OP_WP_LOW:  rp0_d = {opB_q[7:3], 3'h0}; // [RULE11]
			OP_WP_HIGH: rp1_d = {opB_q[7:3], 3'h0}; // [RULE12]
			OP_PUSH_S:
			begin
				res_d = wd ? opA_q : {8'h00, opA_q[7:0]}; // [RULE13]
				ssp_d = ssp_q - stepSz;
			end
			OP_EA_PUSH_S:
			begin
				res_d = opA_q + opB_q; // [RULE13]
				ssp_d = ssp_q - STEP_WORD;
			end
			OP_PULL_S:
			begin
				res_d = wd ? opB_q : {8'h00, opB_q[7:0]}; // [RULE15]
				ssp_d = ssp_q + stepSz;
			end
			OP_PUSH_U:
			begin
				res_d = wd ? opA_q : {8'h00, opA_q[7:0]}; // [RULE14]
				usp_d = usp_q - stepSz;
			end
			OP_EA_PUSH_U:
			begin
				res_d = opA_q + opB_q; // [RULE14]
				usp_d = usp_q - STEP_WORD;
			end
			OP_PULL_U:
			begin
				res_d = wd ? opB_q : {8'h00, opB_q[7:0]}; // [RULE16]
				usp_d = usp_q + stepSz;
			end
			OP_DIVIDE:
			begin
				res_d     = {rem[7:0], quo[7:0]}; // [RULE17]
				flags_d.c = 1'b1;
				flags_d.d = 1'b1;
				flags_d.z = quo[7:0] == 8'h00;
				flags_d.s = quo[7];
			end
			OP_DIV_STEP:
			begin
				// one restoring step: the dividend bit enters through carry, the quotient bit leaves in it
				res_d     = stepFit ? stepSub[15:0] : stepRem[15:0]; // [RULE17]
				flags_d.c = stepFit;
			end
			OP_ASR:
			begin
				res_d     = wd ? {opA_q[15], opA_q[15:1]} : {8'h00, opA_q[7], opA_q[7:1]}; // [RULE18]
				flags_d.c = opA_q[0];
				flags_d.z = isZero(res_d, wd);
				flags_d.s = aSign;
				flags_d.v = 1'b0;
				flags_d.d = 1'b0;
				flags_d.h = 1'b0;
			end
			OP_CROT_R:
			begin
				res_d     = wd ? {flags_q.c, opA_q[15:1]} : {8'h00, flags_q.c, opA_q[7:1]}; // [RULE19]
				flags_d.c = opA_q[0];
				flags_d.z = isZero(res_d, wd);
				flags_d.s = signOf(res_d, wd);
				flags_d.v = signOf(res_d, wd) ^ aSign;
			end
			OP_CROT_L:
			begin
				res_d     = wd ? {opA_q[14:0], flags_q.c} : {8'h00, opA_q[6:0], flags_q.c}; // [RULE20]
				flags_d.c = aSign;
				flags_d.z = isZero(res_d, wd);
				flags_d.s = signOf(res_d, wd);
				flags_d.v = signOf(res_d, wd) ^ aSign;
			end
			OP_ASL:
			begin
				res_d     = wd ? {opA_q[14:0], 1'b0} : {8'h00, opA_q[6:0], 1'b0}; // [RULE21]
				flags_d.c = aSign;
				flags_d.z = isZero(res_d, wd);
				flags_d.s = signOf(res_d, wd);
				flags_d.v = signOf(res_d, wd) ^ aSign;
				flags_d.h = wd ? flags_q.h : opA_q[3];
			end
			OP_IRQ_EXIT:
			begin
				flags_d = cib_flags_s'({opA_q[7:2], flags_q.user, flags_q.pd}); // [RULE22]
				pc_d    = opB_q;
			end
			OP_C_SET: flags_d.c = 1'b1; // [RULE22]
			OP_C_CLR: flags_d.c = 1'b0; // [RULE22]
			OP_C_INV: flags_d.c = ~flags_q.c; // [RULE22]
			OP_PROD8:
			begin
				res_d     = prod; // [RULE23]
				flags_d.c = prod[15:8] != 8'h00;
				flags_d.z = prod == 16'h0000;
				flags_d.s = prod[15];
				flags_d.v = 1'b0;
				flags_d.d = 1'b0;
			end
			OP_INVERT:
			begin
				res_d     = wd ? ~opA_q : {8'h00, ~opA_q[7:0]}; // [RULE23]
				flags_d.z = isZero(res_d, wd);
				flags_d.s = signOf(res_d, wd);
				flags_d.v = 1'b0;
			end
			OP_PSPACE: flags_d.pd = 1'b1; // [RULE25]
			OP_DSPACE: flags_d.pd = 1'b0; // [RULE25]
			default:   res_d = res_q;
		endcase
		if (taken)
			pc_d = brTarget;
	end

	// software writes and execution never meet: they use different offsets
	cib_flags_s flagsNxt;
	assign flagsNxt = exeGo ? flags_d : (wrDone & hitFlags) ? cib_flags_s'(pwdata[7:0]) : flags_q; // [RULE24]
	wire [15:0] pcNxt  = exeGo ? pc_d : (wrDone & hitPc) ? pwdata[15:0] : pc_q;
	wire [15:0] sspNxt = exeGo ? ssp_d : (wrDone & hitSsp) ? pwdata[15:0] : ssp_q;
	wire [15:0] uspNxt = exeGo ? usp_d : (wrDone & hitUsp) ? pwdata[15:0] : usp_q;
	wire [15:0] idxNxt = exeGo ? idx_d : (wrDone & hitIdx) ? pwdata[15:0] : idx_q;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flags_q <= cib_flags_s'(RST_FLAGS);
			pc_q    <= RST_PC;
			ssp_q   <= RST_SP;
			usp_q   <= RST_SP;
			idx_q   <= 16'h0000;
		end
		else
		begin
			flags_q <= flagsNxt;
			pc_q    <= pcNxt;
			ssp_q   <= sspNxt;
			usp_q   <= uspNxt;
			idx_q   <= idxNxt;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			res_q <= 16'h0000;
			rp0_q <= RST_PTR;
			rp1_q <= RST_PTR;
		end
		else if (exeGo)
		begin
			res_q <= res_d;
			rp0_q <= rp0_d;
			rp1_q <= rp1_d;
		end
	end

	// core state: run, wait for interrupt, dma slot inside wait, halt
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
				if (exeGo & goHalt)
					state_d = ST_HALT; // [RULE3]
				else if (exeGo & goWait)
					state_d = ST_WAIT; // [RULE1]
			ST_WAIT:
				if (irqSeen & ie_q)
					state_d = ST_RUN; // [RULE1]
				else if (dmaSeen)
					state_d = ST_DMA; // [RULE2]
			ST_DMA:
				if (dmaCnt_q == CNT_W'(1))
					state_d = ST_WAIT; // [RULE2]
			ST_HALT: state_d = ST_HALT; // [RULE3]
			default: state_d = ST_RUN;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q   <= ST_RUN;
			dmaCnt_q  <= '0;
			waiting_q <= 1'b0;
			halted_q  <= 1'b0;
			dmaBusy_q <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			dmaCnt_q  <= (state_q == ST_DMA) ? dmaCnt_q - CNT_W'(1) : CNT_W'(DMA_SVC_CYC);
			waiting_q <= state_d == ST_WAIT;
			halted_q  <= state_d == ST_HALT;
			dmaBusy_q <= state_d == ST_DMA;
		end
	end

	assign prdata      = rdData_q;
	assign pready      = ready_q;
	assign pslverr     = err_q;
	assign pdSelect    = flags_q.pd; // [RULE25]
	assign coreWaiting = waiting_q;
	assign coreHalted  = halted_q;
	assign dmaBusy     = dmaBusy_q;

	// checks on the design's own behaviour
	default clocking cbClk @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_exec(cib_op_e o);
		exeGo && (cmdIn.op == o);
	endsequence
	sequence s_dma_start;
		(state_q == ST_WAIT) && !(irqSeen && ie_q) && dmaSeen;
	endsequence

	property p_wait_enter;
		s_exec(OP_WAIT_INT) |=> (state_q == ST_WAIT) && waiting_q;
	endproperty
	a_wait_enter: assert property (p_wait_enter) else $error("wait op did not idle"); // [RULE1]
	property p_wait_wake;
		(state_q == ST_WAIT) && irqSeen && ie_q |=> (state_q == ST_RUN) && !waiting_q;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("enabled interrupt did not wake"); // [RULE1]
	property p_dma_slot;
		s_dma_start |=> dmaBusy_q [*8] ##1 (!dmaBusy_q && state_q == ST_WAIT);
	endproperty
	a_dma_slot: assert property (p_dma_slot) else $error("dma slot wrong length"); // [RULE2]
	property p_halt_stays;
		state_q == ST_HALT |=> (state_q == ST_HALT) && halted_q && !exeGo;
	endproperty
	a_halt_stays: assert property (p_halt_stays) else $error("halt left without reset"); // [RULE3]
	property p_cjf_inc;
		s_exec(OP_CJF_INC) && opEqual |=> (idx_q == $past(idx_q) + $past(stepSz)) && (flags_q == $past(flags_q));
	endproperty
	a_cjf_inc: assert property (p_cjf_inc) else $error("compare false did not increment"); // [RULE4]
	property p_cjt_jump;
		s_exec(OP_CJT_INC) && opEqual |=> pc_q == $past(brTarget);
	endproperty
	a_cjt_jump: assert property (p_cjt_jump) else $error("compare true did not branch"); // [RULE5]
	property p_dec_last;
		s_exec(OP_DEC_BNZ) && (opA_q[7:0] == 8'h01) |=> (pc_q == $past(pc_q) + 16'h0001) && (res_q[7:0] == 8'h00);
	endproperty
	a_dec_last: assert property (p_dec_last) else $error("decrement to zero branched"); // [RULE7]
	property p_divide_flags;
		s_exec(OP_DIVIDE) |=> flags_q.c && flags_q.d;
	endproperty
	a_divide_flags: assert property (p_divide_flags) else $error("divide flags wrong"); // [RULE17]
	property p_asr_flags;
		s_exec(OP_ASR) |=> !flags_q.d && !flags_q.v && (flags_q.c == $past(opA_q[0]));
	endproperty
	a_asr_flags: assert property (p_asr_flags) else $error("right shift flags wrong"); // [RULE18]
	property p_user_stack;
		s_exec(OP_PUSH_U) |=> (ssp_q == $past(ssp_q)) && (usp_q == $past(usp_q) - $past(stepSz));
	endproperty
	a_user_stack: assert property (p_user_stack) else $error("user push moved wrong pointer"); // [RULE14]
	property p_carry_inv;
		s_exec(OP_C_INV) |=> (flags_q.c != $past(flags_q.c)) && (flags_q.z == $past(flags_q.z));
	endproperty
	a_carry_inv: assert property (p_carry_inv) else $error("carry invert wrong"); // [RULE22]
	property p_space_pin;
		s_exec(OP_PSPACE) |=> pdSelect ##1 pdSelect;
	endproperty
	a_space_pin: assert property (p_space_pin) else $error("space pin not set"); // [RULE25]
endmodule
`default_nettype wire

// ==== dv/test_cib_core.sv ====
// test_cib_core: directed apb bench for the instruction behaviour core
// assumes cib_pkg is compiled first and the core answers every transfer within a few cycles
`default_nettype none
module test_cib_core;
	timeunit 1ns;
	timeprecision 1ps;
	import cib_pkg::*;

	logic        clock;
	logic        sysRst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irqReq;
	logic        dmaReq;
	logic        pdSelect;
	logic        coreWaiting;
	logic        coreHalted;
	logic        dmaBusy;
	int          mismatches;
	int          nChecks;
	int          n;
	logic [31:0] rdv;
	logic        err;
	logic [15:0] idxX;
	logic [7:0]  fl;
	// stack table: op, width, result, system and user pointer after each step
	cib_op_e     sOp [7]  = '{OP_PUSH_S, OP_PUSH_S, OP_EA_PUSH_S, OP_PULL_S, OP_EA_PUSH_U, OP_PUSH_U, OP_PULL_U};
	logic [6:0]  sWide    = 7'b1011110;
	logic [15:0] sRes [7] = '{16'h0034, 16'h1234, 16'h1236, 16'h0002, 16'h1236, 16'h0034, 16'h0002};
	logic [7:0]  sSsp [7] = '{8'hFE, 8'hFC, 8'hFA, 8'hFC, 8'hFC, 8'hFC, 8'hFC};
	logic [7:0]  sUsp [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFD, 8'hFC, 8'hFE};

	cib_core cib_core_inst
	(
		.clock(clock), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irqReq(irqReq), .dmaReq(dmaReq), .pdSelect(pdSelect), .coreWaiting(coreWaiting),
		.coreHalted(coreHalted), .dmaBusy(dmaBusy)
	);

	// 40 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// one transfer; pready, read data and error are taken at the rising edge that completes it
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && n < 16)
		begin
			@(posedge clock);
			n++;
		end
		if (n == 16)
			mismatches++;
		rdv = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		cmp(nm, rdv, exp);
	endtask

	// operands first, then the command word with displacement 10h
	task automatic ex(input cib_op_e op, input logic w, input logic [3:0] s, input logic [15:0] a,
		input logic [15:0] b);
		cib_cmd_s c;
		c = '{disp: 8'h10, rsvA: 4'h0, sel: s, wide: w, rsvB: 1'b0, op: op};
		xfer(1'b1, OFS_OPA, {16'h0, a});
		xfer(1'b1, OFS_OPB, {16'h0, b});
		xfer(1'b1, OFS_CMD, {8'h00, c});
	endtask

	// from pc 0100h a taken branch lands on 0110h, otherwise 0101h
	task automatic br(input cib_op_e op, input logic w, input logic [3:0] s, input logic [15:0] a,
		input logic [15:0] b, input logic tk);
		xfer(1'b1, OFS_PC, 32'h0000_0100);
		ex(op, w, s, a, b);
		rd(OFS_PC, "pc", tk ? 32'h0000_0110 : 32'h0000_0101);
	endtask

	// condition truth from c z s v, indexed by condition code
	function automatic logic cc(input logic [3:0] s, input logic [7:0] f);
		logic        c, z, m, v;
		logic [15:0] t;
		{c, z, m, v} = f[7:4];
		t = {c | z, ~c & ~z, z | (m ^ v), ~(z | (m ^ v)), m ^ v, ~(m ^ v), ~v, v, m, ~m, ~z, z, ~c, c, 2'b10};
		return t[s];
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// a full run is under 3000 cycles; a hang is cut well beyond that
	initial
	begin
		repeat (40000) @(posedge clock);
		mismatches++;
		results();
	end

	initial
	begin
		mismatches = 0;
		nChecks = 0;
		{sysRst, psel, penable, pwrite, irqReq, dmaReq} = 6'b100000;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge clock);
		sysRst <= 1'b0;
		@(posedge clock);
		rd(OFS_FLAGS, "flags", 32'h0000_E700);
		rd(OFS_SSP, "ssp", 32'h0000_00FF);
		xfer(1'b0, 8'h3C, 32'h0);
		cmp("unmapped", {31'h0, err}, 32'h1);
		$display("test reset done");
		for (int p = 0; p < 2; p++)
		begin
			fl = p ? 8'h50 : 8'hA0;
			xfer(1'b1, OFS_FLAGS, {24'h0, fl});
			for (int s = 0; s < 16; s++)
				br(OP_REL_BR, 1'b0, s[3:0], 16'h0, 16'h0, cc(s[3:0], fl));
		end
		for (int i = 0; i < 4; i++)
			br(i[0] ? OP_BTB_T : OP_BTB_F, 1'b0, {3'b001, i[1]}, 16'h0004, 16'h0, i[0] ^ i[1]);
		br(OP_DEC_BNZ, 1'b0, 4'h0, 16'h0101, 16'h0, 1'b0);
		br(OP_PDEC_BNZ, 1'b1, 4'h0, 16'h0100, 16'h0, 1'b1);
		rd(OFS_RES, "res", 32'h0000_00FF);
		xfer(1'b1, OFS_IDX, 32'h0000_0010);
		idxX = 16'h0010;
		for (int i = 0; i < 4; i++)
		begin
			br(i[0] ? OP_CJT_INC : OP_CJF_INC, i[0], 4'h0, 16'h0005, {15'h2, ~i[1]}, i[0] ^ i[1]);
			if (!(i[0] ^ i[1]))
				idxX += i[0] ? 16'h0002 : 16'h0001;
			rd(OFS_IDX, "idx", {16'h0, idxX});
		end
		rd(OFS_FLAGS, "flags", 32'h0000_E750);
		$display("test branches done");
		ex(OP_WP_LONG, 1'b0, 4'h0, 16'h0, 16'h0035);
		rd(OFS_PTR, "ptr", 32'h0000_3830);
		ex(OP_WP_LOW, 1'b0, 4'h0, 16'h0, 16'h004D);
		rd(OFS_PTR, "ptr", 32'h0000_3848);
		ex(OP_WP_HIGH, 1'b0, 4'h0, 16'h0, 16'h0097);
		rd(OFS_PTR, "ptr", 32'h0000_9048);
		xfer(1'b1, OFS_FLAGS, 32'h0000_00FC);
		for (int i = 0; i < 7; i++)
		begin
			ex(sOp[i], sWide[i], 4'h0, 16'h1234, 16'h0002);
			rd(OFS_RES, "res", {16'h0, sRes[i]});
			rd(OFS_SSP, "ssp", {24'h0, sSsp[i]});
			rd(OFS_USP, "usp", {24'h0, sUsp[i]});
		end
		rd(OFS_FLAGS, "flags", 32'h0000_E7FC);
		$display("test pointers and stacks done");
		xfer(1'b1, OFS_FLAGS, 32'h0);
		ex(OP_DIVIDE, 1'b0, 4'h0, 16'h0007, 16'h0002);
		rd(OFS_RES, "res", 32'h0000_0103);
		rd(OFS_FLAGS, "flags", 32'h0000_E788);
		ex(OP_ASR, 1'b0, 4'h0, 16'h0081, 16'h0);
		rd(OFS_FLAGS, "flags", 32'h0000_E7A0);
		xfer(1'b1, OFS_FLAGS, 32'h0000_0010);
		ex(OP_INVERT, 1'b0, 4'h0, 16'h00FF, 16'h0);
		rd(OFS_FLAGS, "flags", 32'h0000_E740);
		xfer(1'b1, OFS_FLAGS, 32'h0000_0008);
		ex(OP_PROD8, 1'b0, 4'h0, 16'h0, 16'h0033);
		rd(OFS_FLAGS, "flags", 32'h0000_E740);
		xfer(1'b1, OFS_FLAGS, 32'h0000_0002);
		ex(OP_IRQ_EXIT, 1'b0, 4'h0, 16'h00FC, 16'h0040);
		rd(OFS_FLAGS, "flags", 32'h0000_E7FE);
		rd(OFS_PC, "pc", 32'h0000_0040);
		ex(OP_C_CLR, 1'b0, 4'h0, 16'h0, 16'h0);
		rd(OFS_FLAGS, "flags", 32'h0000_E77E);
		ex(OP_C_SET, 1'b0, 4'h0, 16'h0, 16'h0);
		rd(OFS_FLAGS, "flags", 32'h0000_E7FE);
		ex(OP_C_INV, 1'b0, 4'h0, 16'h0, 16'h0);
		rd(OFS_FLAGS, "flags", 32'h0000_E77E);
		ex(OP_PSPACE, 1'b0, 4'h0, 16'h0, 16'h0);
		cmp("pd pin", {31'h0, pdSelect}, 32'h1);
		rd(OFS_FLAGS, "flags", 32'h0000_E77F);
		ex(OP_DSPACE, 1'b0, 4'h0, 16'h0, 16'h0);
		cmp("pd pin", {31'h0, pdSelect}, 32'h0);
		ex(OP_CROT_L, 1'b0, 4'h0, 16'h0081, 16'h0);
		rd(OFS_FLAGS, "flags", 32'h0000_E79E);
		ex(OP_CROT_R, 1'b0, 4'h0, 16'h0081, 16'h0);
		rd(OFS_FLAGS, "flags", 32'h0000_E7AE);
		ex(OP_ASL, 1'b0, 4'h0, 16'h0048, 16'h0);
		rd(OFS_FLAGS, "flags", 32'h0000_E73E);
		ex(OP_DIV_STEP, 1'b0, 4'h0, 16'h0005, 16'h0003);
		rd(OFS_RES, "res", 32'h0000_0007);
		rd(OFS_FLAGS, "flags", 32'h0000_E7BE);
		$display("test flags done");
		xfer(1'b1, OFS_CTRL, 32'h1);
		ex(OP_WAIT_INT, 1'b0, 4'h0, 16'h0, 16'h0);
		cmp("waiting", {31'h0, coreWaiting}, 32'h1);
		xfer(1'b1, OFS_CMD, 32'h0);
		cmp("cmd refused", {31'h0, err}, 32'h1);
		// a one-cycle request is enough for the synchroniser and avoids a second slot
		dmaReq <= 1'b1;
		@(posedge clock);
		dmaReq <= 1'b0;
		for (n = 0; dmaBusy !== 1'b1 && n < 12; n++)
			@(negedge clock);
		for (n = 0; dmaBusy === 1'b1 && n < 12; n++)
			@(negedge clock);
		cmp("dma slot", 32'(n), 32'(DMA_SVC_CYC));
		cmp("waiting", {31'h0, coreWaiting}, 32'h1);
		@(posedge clock);
		irqReq <= 1'b1;
		repeat (6) @(posedge clock);
		cmp("woken", {31'h0, coreWaiting}, 32'h0);
		ex(OP_HALT, 1'b0, 4'h0, 16'h0, 16'h0);
		repeat (8) @(posedge clock);
		cmp("halted", {31'h0, coreHalted}, 32'h1);
		xfer(1'b1, OFS_CMD, 32'h0);
		cmp("cmd refused", {31'h0, err}, 32'h1);
		irqReq <= 1'b0;
		sysRst <= 1'b1;
		@(posedge clock);
		sysRst <= 1'b0;
		@(posedge clock);
		cmp("halted", {31'h0, coreHalted}, 32'h0);
		$display("test wait and halt done");
		results();
	end
endmodule
`default_nettype wire
